/* src/tacc_consts.svh */
/*
  Constants of the accelerometer reader: clocks, sensor map, APB map.
  Assumes inclusion by bare name.
*/
`ifndef TACC_CONSTS_SVH
`define TACC_CONSTS_SVH

// clock rates
`define TACC_CLK_HZ        200000000
`define TACC_CTRL_HZ       10000000

// sensor addresses
`define TACC_SA_EVENT      6'h30
`define TACC_SA_FORMAT     6'h31
`define TACC_SA_AXIS0      6'h32
`define TACC_SA_RATE       6'h2c
`define TACC_SA_POWER      6'h2d

// sensor register values
// serial-mode bit D6 set, 10-bit, right-justified, +/-2 g range
`define TACC_FMT_VAL       8'h40
// output data rate code for 400 Hz
`define TACC_RATE_VAL      8'h0c
// measurement mode on
`define TACC_PWR_VAL       8'h08
`define TACC_BURST_LEN     3'h6
`define TACC_NO_BYTES      3'h0
`define TACC_ONE_BYTE      3'h1

// event flags byte
`define TACC_EV_READY_BIT  7
`define TACC_EV_OVR_BIT    0

// command byte layout
`define TACC_CMD_RD_BIT    7
`define TACC_CMD_MB_BIT    6

// APB register byte offsets
`define TACC_OFS_CTRL      8'h00
`define TACC_OFS_STATUS    8'h04
`define TACC_OFS_INT_STAT  8'h08
`define TACC_OFS_INT_MASK  8'h0c
`define TACC_OFS_AXIS_X    8'h10
`define TACC_OFS_AXIS_Y    8'h14
`define TACC_OFS_AXIS_Z    8'h18
`define TACC_OFS_EVENT     8'h1c

// field positions
`define TACC_CTRL_EN_BIT   0
`define TACC_INT_SAMPLE    0
`define TACC_INT_OVR       1
`define TACC_INT_CFG       2
`define TACC_INT_W         3

`endif

/* src/tacc_pkg.sv */
/*
  Types of the three-wire accelerometer reader.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tacc_pkg;
    typedef enum logic [2:0] {
        TACC_ST_IDLE  = 3'b000,
        TACC_ST_FMT   = 3'b001,
        TACC_ST_RATE  = 3'b010,
        TACC_ST_PWR   = 3'b011,
        TACC_ST_POLL  = 3'b100,
        TACC_ST_BURST = 3'b101
    } tacc_state_e;

    typedef logic [7:0] tacc_byte_t;
endpackage : tacc_pkg

/* src/tacc_spi_shifter.sv */
/*
  Bit engine of the link: a frame of a command byte and up to
  six data bytes.
  Assumes a data-line input already synchronised to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module tacc_spi_shifter
    import tacc_pkg::*;
#(
    parameter int HALF_CYC = 20
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       start_i,
    input  wire logic       rnw_i,
    input  wire tacc_byte_t cmd_i,
    input  wire tacc_byte_t wdata_i,
    input  wire logic [2:0] nbytes_i,
    input  wire logic       sdio_sync_i,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic            sdio_o,
    output logic            sdio_oe_n_o,
    output tacc_byte_t      rx_byte_o,
    output logic            rx_valid_o,
    output logic            done_o,
    output logic            busy_o
);
    localparam int DW = $clog2(HALF_CYC);

    logic [DW-1:0] div_reg;
    logic          tick;
    logic [5:0]    bit_reg;
    logic [5:0]    nbits_reg;
    logic [15:0]   tx_reg;
    logic [6:0]    rx_reg;
    logic          rnw_reg;
    logic          end_reg;

    assign tick = busy_o && (div_reg == DW'(HALF_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !busy_o || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        rx_valid_o <= 1'b0;
        done_o     <= 1'b0;
        if (!rst_n_i) begin
            sclk_o      <= 1'b1;
            cs_n_o      <= 1'b1;
            sdio_o      <= 1'b0;
            sdio_oe_n_o <= 1'b1;
            busy_o      <= 1'b0;
            end_reg     <= 1'b0;
            bit_reg     <= '0;
            nbits_reg   <= '0;
            tx_reg      <= '0;
            rx_reg      <= '0;
            rnw_reg     <= 1'b0;
            rx_byte_o   <= '0;
        end else if (start_i && !busy_o) begin
            cs_n_o    <= 1'b0;
            busy_o    <= 1'b1;
            bit_reg   <= '0;
            nbits_reg <= {nbytes_i + 3'h1, 3'h0};
            tx_reg    <= {cmd_i, wdata_i};
            rnw_reg   <= rnw_i;
        end else if (tick && end_reg) begin
            cs_n_o      <= 1'b1;
            sdio_oe_n_o <= 1'b1;
            busy_o      <= 1'b0;
            end_reg     <= 1'b0;
            done_o      <= 1'b1;
        end else if (tick && sclk_o) begin
            if (bit_reg == nbits_reg) begin
                end_reg <= 1'b1;
            end else begin
                sclk_o <= 1'b0;
                if (bit_reg < 6'h08 || !rnw_reg) begin
                    sdio_o      <= tx_reg[15];
                    sdio_oe_n_o <= 1'b0;
                    tx_reg      <= {tx_reg[14:0], 1'b0};
                end else begin
                    sdio_oe_n_o <= 1'b1;
                end
            end
        end else if (tick) begin
            sclk_o  <= 1'b1;
            bit_reg <= bit_reg + 6'h01;
            if (rnw_reg && bit_reg >= 6'h08) begin
                rx_reg <= {rx_reg[5:0], sdio_sync_i};
                if (bit_reg[2:0] == 3'h7) begin
                    rx_byte_o  <= {rx_reg, sdio_sync_i};
                    rx_valid_o <= 1'b1;
                end
            end
        end
    end
endmodule : tacc_spi_shifter

`default_nettype wire

/* src/tacc_reader.sv */
/*
  Accelerometer reader: sets up the sensor, polls its flags
  and fetches the axes in one burst;
  APB slave with sticky interrupt flags.
  Assumes an APB master on clk_i and a sensor on the data pin.
*/
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

`include "tacc_consts.svh"

// Functional notes
// - write one to serial-mode bit of format register 0x31 before reading axes
// - format set to 10-bit, right-justified, plus or minus 2 g
// - data rate programmed to 400 Hz during configuration, before polling
// - read event flags before each axis read, go on only when sample available
// - axes fetched as one six-byte burst from 0x32 to 0x37
// - serial clock idles high between frames, polarity 1 phase 1
// - driver changes data on falling edge, receiver samples on rising edge
// - link logic paced at 10 MHz derived from the system clock
module tacc_reader
    import tacc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    output logic             sclk_o,
    output logic             cs_n_o,
    output logic             sdio_o,
    output logic             sdio_oe_n_o,
    input  wire logic        sdio_i
);
    // clocks per half serial period
    localparam int HALF_CYC = `TACC_CLK_HZ / `TACC_CTRL_HZ;

    tacc_state_e state_reg;
    tacc_state_e state_next;

    logic        enable_reg;
    logic        cfg_done_reg;
    logic        issued_reg;
    logic        start_reg;
    logic        rnw_reg;
    tacc_byte_t  cmd_reg;
    tacc_byte_t  wdata_reg;
    logic [2:0]  nbytes_reg;
    logic [2:0]  idx_reg;
    tacc_byte_t  event_reg;
    tacc_byte_t  shadow_reg [6];
    logic [15:0] axis_x_reg;
    logic [15:0] axis_y_reg;
    logic [15:0] axis_z_reg;

    logic [`TACC_INT_W-1:0] int_stat_reg;
    logic [`TACC_INT_W-1:0] int_mask_reg;
    logic [`TACC_INT_W-1:0] int_set;

    logic       sdio_meta_reg;
    logic       sdio_sync_reg;
    tacc_byte_t rx_byte;
    logic       rx_valid;
    logic       xfer_done;
    logic       xfer_busy;

    logic        apb_setup;
    logic        apb_wr;
    logic        mapped;
    logic [31:0] rd_mux;

    // data pin passes two flops before the shifter
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sdio_meta_reg <= 1'b0;
            sdio_sync_reg <= 1'b0;
        end else begin
            sdio_meta_reg <= sdio_i;
            sdio_sync_reg <= sdio_meta_reg;
        end
    end

    tacc_spi_shifter #(
        .HALF_CYC    (HALF_CYC)
    ) u_shifter (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .start_i     (start_reg),
        .rnw_i       (rnw_reg),
        .cmd_i       (cmd_reg),
        .wdata_i     (wdata_reg),
        .nbytes_i    (nbytes_reg),
        .sdio_sync_i (sdio_sync_reg),
        .sclk_o      (sclk_o),
        .cs_n_o      (cs_n_o),
        .sdio_o      (sdio_o),
        .sdio_oe_n_o (sdio_oe_n_o),
        .rx_byte_o   (rx_byte),
        .rx_valid_o  (rx_valid),
        .done_o      (xfer_done),
        .busy_o      (xfer_busy)
    );

    // sequencer: every state but idle leaves only when its own frame has ended,
    // so disabling never cuts a frame short
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TACC_ST_IDLE: begin
                if (enable_reg) begin
                    state_next = TACC_ST_FMT;
                end
            end
            TACC_ST_FMT: begin
                if (xfer_done) begin
                    state_next = enable_reg ? TACC_ST_RATE : TACC_ST_IDLE;
                end
            end
            TACC_ST_RATE: begin
                if (xfer_done) begin
                    state_next = enable_reg ? TACC_ST_PWR : TACC_ST_IDLE;
                end
            end
            TACC_ST_PWR: begin
                if (xfer_done) begin
                    state_next = enable_reg ? TACC_ST_POLL : TACC_ST_IDLE;
                end
            end
            TACC_ST_POLL: begin
                if (xfer_done) begin
                    if (!enable_reg) begin
                        state_next = TACC_ST_IDLE;
                    end else if (event_reg[`TACC_EV_READY_BIT]) begin
                        state_next = TACC_ST_BURST;
                    end
                end
            end
            TACC_ST_BURST: begin
                if (xfer_done) begin
                    state_next = enable_reg ? TACC_ST_POLL : TACC_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= TACC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // issued_reg: one frame at a time, cleared when a frame ends or the state changes
    always_ff @(posedge clk_i) begin
        start_reg <= 1'b0;
        if (!rst_n_i) begin
            issued_reg <= 1'b0;
            rnw_reg    <= 1'b0;
            cmd_reg    <= '0;
            wdata_reg  <= '0;
            nbytes_reg <= '0;
        end else if (state_next != state_reg || xfer_done) begin
            issued_reg <= 1'b0;
        end else if (!issued_reg && !xfer_busy && state_reg != TACC_ST_IDLE) begin
            issued_reg <= 1'b1;
            start_reg  <= 1'b1;
            unique case (state_reg)
                TACC_ST_FMT: begin
                    rnw_reg    <= 1'b0;
                    cmd_reg    <= {2'b00, `TACC_SA_FORMAT};
                    wdata_reg  <= `TACC_FMT_VAL;
                    nbytes_reg <= `TACC_ONE_BYTE;
                end
                TACC_ST_RATE: begin
                    rnw_reg    <= 1'b0;
                    cmd_reg    <= {2'b00, `TACC_SA_RATE};
                    wdata_reg  <= `TACC_RATE_VAL;
                    nbytes_reg <= `TACC_ONE_BYTE;
                end
                TACC_ST_PWR: begin
                    rnw_reg    <= 1'b0;
                    cmd_reg    <= {2'b00, `TACC_SA_POWER};
                    wdata_reg  <= `TACC_PWR_VAL;
                    nbytes_reg <= `TACC_ONE_BYTE;
                end
                TACC_ST_POLL: begin
                    rnw_reg    <= 1'b1;
                    cmd_reg    <= {1'b1, 1'b0, `TACC_SA_EVENT};
                    wdata_reg  <= '0;
                    nbytes_reg <= `TACC_ONE_BYTE;
                end
                TACC_ST_BURST: begin
                    rnw_reg    <= 1'b1;
                    cmd_reg    <= {1'b1, 1'b1, `TACC_SA_AXIS0};
                    wdata_reg  <= '0;
                    nbytes_reg <= `TACC_BURST_LEN;
                end
                default: begin
                    rnw_reg    <= 1'b0;
                    cmd_reg    <= '0;
                    wdata_reg  <= '0;
                    nbytes_reg <= `TACC_NO_BYTES;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_done_reg <= 1'b0;
        end else if (state_reg == TACC_ST_IDLE) begin
            cfg_done_reg <= 1'b0;
        end else if (state_reg == TACC_ST_PWR && xfer_done) begin
            cfg_done_reg <= 1'b1;
        end
    end

    // event flags byte as the sensor lays it out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            event_reg <= '0;
        end else if (rx_valid && state_reg == TACC_ST_POLL) begin
            event_reg <= rx_byte;
        end
    end

    // burst bytes land in a shadow and are committed together,
    // so software never sees axes from two different samples
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idx_reg <= '0;
            for (int i = 0; i < 6; i++) begin
                shadow_reg[i] <= '0;
            end
        end else if (state_reg != TACC_ST_BURST) begin
            idx_reg <= '0;
        end else if (rx_valid) begin
            shadow_reg[idx_reg] <= rx_byte;
            idx_reg             <= idx_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            axis_x_reg <= '0;
            axis_y_reg <= '0;
            axis_z_reg <= '0;
        end else if (state_reg == TACC_ST_BURST && xfer_done) begin
            axis_x_reg <= {shadow_reg[1], shadow_reg[0]};
            axis_y_reg <= {shadow_reg[3], shadow_reg[2]};
            axis_z_reg <= {shadow_reg[5], shadow_reg[4]};
        end
    end

    // interrupt events
    always_comb begin
        int_set                   = '0;
        int_set[`TACC_INT_SAMPLE] = state_reg == TACC_ST_BURST && xfer_done;
        int_set[`TACC_INT_OVR]    = state_reg == TACC_ST_POLL && rx_valid
                                    && rx_byte[`TACC_EV_OVR_BIT];
        int_set[`TACC_INT_CFG]    = state_reg == TACC_ST_PWR && xfer_done;
    end

    // APB: answer prepared in setup, zero wait states
    assign apb_setup = psel_i && !penable_i;
    assign apb_wr    = psel_i && penable_i && pready_o && pwrite_i;

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        unique case (paddr_i)
            `TACC_OFS_CTRL: begin
                rd_mux[`TACC_CTRL_EN_BIT] = enable_reg;
            end
            `TACC_OFS_STATUS: begin
                rd_mux[0]   = xfer_busy;
                rd_mux[1]   = cfg_done_reg;
                rd_mux[4:2] = state_reg;
            end
            `TACC_OFS_INT_STAT: begin
                rd_mux[`TACC_INT_W-1:0] = int_stat_reg;
            end
            `TACC_OFS_INT_MASK: begin
                rd_mux[`TACC_INT_W-1:0] = int_mask_reg;
            end
            `TACC_OFS_AXIS_X: begin
                rd_mux[15:0] = axis_x_reg;
            end
            `TACC_OFS_AXIS_Y: begin
                rd_mux[15:0] = axis_y_reg;
            end
            `TACC_OFS_AXIS_Z: begin
                rd_mux[15:0] = axis_z_reg;
            end
            `TACC_OFS_EVENT: begin
                rd_mux[7:0] = event_reg;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup && !mapped;
            if (apb_setup && !pwrite_i) begin
                prdata_o <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            enable_reg   <= 1'b0;
            int_mask_reg <= '0;
        end else if (apb_wr && paddr_i == `TACC_OFS_CTRL) begin
            enable_reg <= pwdata_i[`TACC_CTRL_EN_BIT];
        end else if (apb_wr && paddr_i == `TACC_OFS_INT_MASK) begin
            int_mask_reg <= pwdata_i[`TACC_INT_W-1:0];
        end
    end

    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            int_stat_reg <= '0;
        end else if (apb_wr && paddr_i == `TACC_OFS_INT_STAT) begin
            int_stat_reg <= (int_stat_reg & ~pwdata_i[`TACC_INT_W-1:0]) | int_set;
        end else begin
            int_stat_reg <= int_stat_reg | int_set;
        end
    end

    // registered: glitch free, one cycle behind the flags
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_stat_reg & int_mask_reg);
        end
    end
endmodule : tacc_reader

`default_nettype wire

/* verification/tacc_reader_sva.sv */
/*
  Port checker of the reader: bus answer and link framing.
  Assumes binding onto tacc_reader; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module tacc_reader_sva (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        irq_o,
    input wire logic        sclk_o,
    input wire logic        cs_n_o,
    input wire logic        sdio_o,
    input wire logic        sdio_oe_n_o,
    input wire logic        sdio_i
);
    logic       sclk_q;
    logic [5:0] rise_cnt;
    logic [4:0] lo_cnt;
    logic       rd_q;

    // rd_q: direction bit of the frame
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_q   <= 1'b1;
            rise_cnt <= 6'h00;
            lo_cnt   <= 5'h00;
            rd_q     <= 1'b0;
        end else begin
            sclk_q   <= sclk_o;
            lo_cnt   <= sclk_o ? 5'h00 : lo_cnt + 5'h01;
            rise_cnt <= cs_n_o ? 6'h00 : rise_cnt + 6'((sclk_o && !sclk_q) ? 1 : 0);
            if (!cs_n_o && sclk_o && !sclk_q && rise_cnt == 6'h00) begin
                rd_q <= sdio_o;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_answer;
        pready_o ##1 !pready_o;
    endsequence

    AST_PREADY_ONCE: assert property (s_setup |=> s_answer)
        else $error("pready not one cycle");
    AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    AST_SCLK_IDLE: assert property (cs_n_o |-> sclk_o)
        else $error("sclk low when idle");
    AST_FRAME_LEAD: assert property ($fell(cs_n_o) |-> sclk_o [*8])
        else $error("sclk low at frame start");
    AST_HALF_PERIOD: assert property ($rose(sclk_o) |-> lo_cnt == 5'd20)
        else $error("sclk low phase wrong");
    AST_DATA_ON_FALL: assert property ((!sdio_oe_n_o && $changed(sdio_o)) |-> $fell(sclk_o))
        else $error("data moved off falling edge");
    AST_CMD_DRIVEN: assert property (($fell(sclk_o) && !cs_n_o && rise_cnt < 6'd8) |-> !sdio_oe_n_o)
        else $error("command bit not driven");
    AST_READ_RELEASE: assert property (($fell(sclk_o) && rise_cnt >= 6'd8 && rd_q) |-> sdio_oe_n_o)
        else $error("line driven in read data");
    AST_IDLE_RELEASE: assert property (cs_n_o |-> sdio_oe_n_o)
        else $error("line driven when idle");
    AST_FRAME_GAP: assert property ($rose(cs_n_o) |-> cs_n_o [*2])
        else $error("frame gap under two cycles");
    AST_FRAME_LEN: assert property ($rose(cs_n_o) |-> (rise_cnt == 6'd16 || rise_cnt == 6'd56))
        else $error("frame bit count wrong");
endmodule : tacc_reader_sva

bind tacc_reader tacc_reader_sva u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .sclk_o(sclk_o),
    .cs_n_o(cs_n_o), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .sdio_i(sdio_i)
);

`default_nettype wire

/* verification/tacc_sensor_model.sv */
/*
  Sensor model on the data line: registers, event flags, bursts.
  Assumes the bench resolves the pin from both enables.
*/
`timescale 1ns/1ps
`default_nettype none

module tacc_sensor_model (
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    input  wire logic sdio_i,
    input  wire logic ready_i,
    input  wire logic ovr_i,
    output logic      sd_o,
    output logic      sd_oe_n_o
);
    logic [7:0] mem [64];
    logic [7:0] cmd = 8'h00;
    logic [7:0] wbyte;
    logic [7:0] cur;
    logic [5:0] a;
    logic [5:0] first_a = 6'h00;
    logic       order_bad = 1'b0;
    logic       rdy_seen = 1'b0;
    int         rcnt = 0;
    int         fcnt = 0;
    int         n_wr = 0;
    int         n_poll = 0;
    int         n_burst = 0;

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {mem[6'h33], mem[6'h32]} = 16'h1234;
        {mem[6'h35], mem[6'h34]} = 16'habcd;
        {mem[6'h37], mem[6'h36]} = 16'hf001;
        sd_o = 1'b0;
        sd_oe_n_o = 1'b1;
    end

    always @(negedge cs_n_i) begin
        rcnt = 0;
        fcnt = 0;
    end

    // a write lands only with a whole data byte
    always @(posedge cs_n_i) begin
        sd_oe_n_o = 1'b1;
        if (!cmd[7] && rcnt >= 16) begin
            if (n_wr == 0) first_a = cmd[5:0];
            mem[cmd[5:0]] = wbyte;
            n_wr++;
        end
    end

    always @(posedge sclk_i) begin
        if (!cs_n_i) begin
            if (rcnt < 8) cmd = {cmd[6:0], sdio_i};
            else if (rcnt < 16) wbyte = {wbyte[6:0], sdio_i};
            rcnt++;
        end
    end

    // read data change on falling edges, low byte first
    always @(negedge sclk_i) begin
        if (!cs_n_i && cmd[7] && fcnt >= 8) begin
            a = cmd[5:0] + (cmd[6] ? 6'((fcnt - 8) / 8) : 6'h00);
            cur = (a == 6'h30) ? {ready_i, 6'h00, ovr_i} : mem[a];
            if (fcnt == 8 && a == 6'h30) begin
                n_poll++;
                rdy_seen = ready_i;
            end
            if (fcnt == 8 && cmd[6]) begin
                n_burst++;
                if (!rdy_seen || !mem[6'h31][6] || mem[6'h2c] !== 8'h0c) order_bad = 1'b1;
                rdy_seen = 1'b0;
            end
            sd_o = cur[7 - ((fcnt - 8) % 8)];
            sd_oe_n_o = 1'b0;
        end
        if (!cs_n_i) fcnt++;
    end
endmodule : tacc_sensor_model

`default_nettype wire

/* verification/tb_three_wire_accel_reader.sv */
/*
  Bench of the reader: APB master and sensor model.
  Assumes the constants header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none

`include "tacc_consts.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t got %h want %h", $time, (g), (e)); end end

module tb_three_wire_accel_reader;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, irq_o, sclk_o, cs_n_o, sdio_o, sdio_oe_n_o;
    logic        m_sd, m_oe_n;
    logic        ready = 1'b0;
    logic        ovr = 1'b0;
    logic        idle_tog = 1'b0;
    wire         sdio;
    int          fails = 0;
    int          compares = 0;

    // undriven pin toggles: stale levels never pass as data
    assign sdio = !sdio_oe_n_o ? sdio_o : (!m_oe_n ? m_sd : idle_tog);

    tacc_reader uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .sclk_o(sclk_o),
        .cs_n_o(cs_n_o), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .sdio_i(sdio)
    );
    tacc_sensor_model sensor (
        .sclk_i(sclk_o), .cs_n_i(cs_n_o), .sdio_i(sdio), .ready_i(ready),
        .ovr_i(ovr), .sd_o(m_sd), .sd_oe_n_o(m_oe_n)
    );

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) idle_tog <= ~idle_tog;

    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        q = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd

    task automatic wait_int(input int b);
        logic [31:0] q;
        int          n;
        n = 0;
        rd(`TACC_OFS_INT_STAT, q);
        while (q[b] !== 1'b1 && n < 3000) begin rd(`TACC_OFS_INT_STAT, q); n++; end
        `CHK(q[b], 1'b1)
    endtask : wait_int

    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        `CHK({sclk_o, cs_n_o, sdio_oe_n_o}, 3'b111)
        rd(`TACC_OFS_STATUS, q);
        `CHK(q, 32'h0)
        apb(1'b1, 8'h20, 32'hffffffff, q, e);
        `CHK(e, 1'b1)
        apb(1'b0, 8'h20, 32'h0, q, e);
        `CHK({e, q}, {1'b1, 32'h0})
        wr(`TACC_OFS_AXIS_X, 32'hffff);
        rd(`TACC_OFS_AXIS_X, q);
        `CHK(q, 32'h0)
    endtask : t_reset

    task automatic t_config;
        logic [31:0] q;
        wr(`TACC_OFS_INT_MASK, 32'h7);
        wr(`TACC_OFS_CTRL, 32'h1);
        wait_int(2);
        `CHK(sensor.first_a, 6'h31)
        `CHK(sensor.mem[6'h31], 8'h40)
        `CHK(sensor.mem[6'h2c], 8'h0c)
        `CHK(sensor.n_burst, 0)
        rd(`TACC_OFS_STATUS, q);
        `CHK({q[1], irq_o}, 2'b11)
        wr(`TACC_OFS_INT_STAT, 32'h4);
        rd(`TACC_OFS_INT_STAT, q);
        `CHK({q, irq_o}, 33'h0)
    endtask : t_config

    task automatic t_poll;
        logic [31:0] q;
        int          p;
        int          n;
        ovr <= 1'b1;
        p = sensor.n_poll;
        n = 0;
        while (sensor.n_poll < p + 3 && n < 5000) begin @(posedge clk_i); n++; end
        `CHK(sensor.n_burst, 0)
        rd(`TACC_OFS_EVENT, q);
        `CHK(q, 32'h1)
        wait_int(1);
        ovr <= 1'b0;
        wr(`TACC_OFS_INT_MASK, 32'h1);
        wr(`TACC_OFS_INT_STAT, 32'h7);
        ready <= 1'b1;
        wait_int(0);
        ready <= 1'b0;
        rd(`TACC_OFS_AXIS_X, q);
        `CHK(q, 32'h1234)
        rd(`TACC_OFS_AXIS_Y, q);
        `CHK(q, 32'habcd)
        rd(`TACC_OFS_AXIS_Z, q);
        `CHK(q, 32'hf001)
        `CHK({sensor.order_bad, irq_o}, 2'b01)
        wr(`TACC_OFS_INT_MASK, 32'h0);
        rd(`TACC_OFS_INT_STAT, q);
        `CHK({q[0], irq_o}, 2'b10)
    endtask : t_poll

    task automatic t_stop;
        logic [31:0] q;
        int          p;
        int          n;
        wr(`TACC_OFS_CTRL, 32'h0);
        n = 0;
        rd(`TACC_OFS_STATUS, q);
        while (q[4:2] !== 3'h0 && n < 3000) begin rd(`TACC_OFS_STATUS, q); n++; end
        p = sensor.n_poll;
        repeat (1000) @(posedge clk_i);
        `CHK({cs_n_o, sclk_o}, 2'b11)
        `CHK(sensor.n_poll, p)
    endtask : t_stop

    initial begin
        #400000;
        fails++;
        $display("BAD %0t timeout", $time);
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_config();
        t_poll();
        t_stop();
        wrap_up();
    end
endmodule : tb_three_wire_accel_reader

`default_nettype wire
